// File: rtl/dmsa_pkg.sv
// constants, request carrier and decode helpers for the data memory sector addressing block
// assumes one system clock and a cpu core that issues one data access per enabled cycle
package dmsa_pkg;

   // ----------------------------------------------------------------
   // address geometry
   // ----------------------------------------------------------------
   localparam int DMSA_ADDR_W = 12; // significant bits of an extended operand address
   localparam int DMSA_SECT_W = 4; // sector field kept from a pointer or the upper four address bits
   localparam int DMSA_OFS_W = 8; // location inside one sector
   localparam int DMSA_GP_W = 7; // general purpose half of one sector
   localparam int DMSA_NUM_SECTORS = 16; // sectors holding general purpose storage
   localparam logic [7:0] DMSA_ZERO = 8'h00; // value of unused and indirect-port reads

   // ----------------------------------------------------------------
   // sector zero special function offsets held by this block
   // ----------------------------------------------------------------
   localparam logic [7:0] DMSA_OFS_IPORT0 = 8'h00; // indirect_port_sector_zero
   localparam logic [7:0] DMSA_OFS_PTR0 = 8'h01; // pointer_sector_zero
   localparam logic [7:0] DMSA_OFS_IPORT1 = 8'h02; // indirect_port_one
   localparam logic [7:0] DMSA_OFS_PTR1_LO = 8'h03; // pointer_one_low
   localparam logic [7:0] DMSA_OFS_PTR1_SEC = 8'h04; // pointer_one_sector
   localparam logic [7:0] DMSA_OFS_PBANK = 8'h0b; // program_bank_pointer
   localparam logic [7:0] DMSA_OFS_IPORT2 = 8'h0c; // indirect_port_two
   localparam logic [7:0] DMSA_OFS_PTR2_LO = 8'h0d; // pointer_two_low
   localparam logic [7:0] DMSA_OFS_PTR2_SEC = 8'h0e; // pointer_two_sector

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] DMSA_PTR_RST = 8'h00; // all pointers after reset
   localparam logic DMSA_PBANK_RST = 1'b0; // program bank after reset
   localparam int DMSA_PBANK_BIT = 0; // only writable bit of program_bank_pointer

   // one cpu data access
   typedef struct packed {
      logic wr; // 1 write, 0 read
      logic ext; // extended instruction, full 12-bit address
      logic bitop; // single-bit set or clear
      logic bitval; // value written by a bit operation
      logic [2:0] bitsel; // bit touched by a bit operation
      logic [DMSA_ADDR_W-1:0] addr; // operand address
      logic [7:0] wdata; // byte written by a plain write
   } dmsa_req_s;

   // which indirect port, if any, an offset of sector zero names
   typedef enum logic [1:0] {DMSA_PORT_NONE, DMSA_PORT0, DMSA_PORT1, DMSA_PORT2} dmsa_port_e;

   // decode of an indirect port; used for the raw and the redirected address
   function automatic dmsa_port_e dmsa_port_of(input logic [DMSA_SECT_W-1:0] sect,
                                               input logic [7:0] ofs);
      dmsa_port_e p;
      p = DMSA_PORT_NONE;
      if (sect == '0)
      begin
         case (ofs)
            DMSA_OFS_IPORT0: p = DMSA_PORT0;
            DMSA_OFS_IPORT1: p = DMSA_PORT1;
            DMSA_OFS_IPORT2: p = DMSA_PORT2;
            default: p = DMSA_PORT_NONE;
         endcase
      end
      return p;
   endfunction : dmsa_port_of

   // byte after a plain write or a single-bit operation
   function automatic logic [7:0] dmsa_merge(input logic [7:0] old, input dmsa_req_s r);
      logic [7:0] v;
      v = r.wdata;
      if (r.bitop)
      begin
         v = old;
         v[r.bitsel] = r.bitval;
      end
      return v;
   endfunction : dmsa_merge

endpackage : dmsa_pkg

// File: rtl/dmsa_core.sv
// data memory sector addressing: pointers, indirect redirection and general purpose storage
// assumes the cpu core drives ACC_EN and ACC_REQ from logic on SYS_CLK
`timescale 1ns/1ns

module dmsa_core
#(
   parameter int NUM_SECTORS = dmsa_pkg::DMSA_NUM_SECTORS // sectors with storage
)
(
   input wire logic SYS_CLK, // 25 MHz system clock
   input wire logic RESET_N, // synchronous reset, active low
   input wire logic ACC_EN, // access taken on this edge
   input wire dmsa_pkg::dmsa_req_s ACC_REQ, // access details
   output logic [7:0] RD_DATA, // read result, one cycle after the access
   output logic RD_VALID, // pulse marking RD_DATA
   output logic PROG_BANK // program memory bank select
);
   import dmsa_pkg::*;

   localparam int GP_IDX_W = DMSA_SECT_W + DMSA_GP_W;
   localparam int GP_DEPTH = NUM_SECTORS * (2 ** DMSA_GP_W);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] ptr0_q; // pointer_sector_zero
   logic [7:0] ptr1_lo_q; // pointer_one_low
   logic [7:0] ptr1_sec_q; // pointer_one_sector
   logic [7:0] ptr2_lo_q; // pointer_two_low
   logic [7:0] ptr2_sec_q; // pointer_two_sector
   logic pbank_q; // program_bank_pointer bit
   logic [7:0] gp_mem [GP_DEPTH]; // general purpose storage
   logic [7:0] rd_data_q;
   logic rd_valid_q;

   // ----------------------------------------------------------------
   // address forming
   // ----------------------------------------------------------------
   logic [DMSA_SECT_W-1:0] raw_sect;
   logic [7:0] raw_ofs;
   dmsa_port_e raw_port;
   logic [DMSA_SECT_W-1:0] tgt_sect;
   logic [7:0] tgt_ofs;
   dmsa_port_e tgt_port;
   logic gp_sel;
   logic sfr_sel;
   logic [GP_IDX_W-1:0] gp_idx;
   logic [7:0] old_byte;
   logic [7:0] new_byte;

   // standard instructions only see sector zero; extended ones carry the sector
   assign raw_sect = ACC_REQ.ext ? ACC_REQ.addr[DMSA_ADDR_W-1:DMSA_OFS_W] : '0;
   assign raw_ofs = ACC_REQ.addr[DMSA_OFS_W-1:0];
   assign raw_port = dmsa_port_of(raw_sect, raw_ofs);

   // redirect once; program bank is deliberately absent from this mux
   always_comb
   begin
      tgt_sect = raw_sect;
      tgt_ofs = raw_ofs;
      case (raw_port)
         DMSA_PORT0:
         begin
            tgt_sect = '0;
            tgt_ofs = ptr0_q;
         end
         DMSA_PORT1:
         begin
            tgt_sect = ptr1_sec_q[DMSA_SECT_W-1:0];
            tgt_ofs = ptr1_lo_q;
         end
         DMSA_PORT2:
         begin
            tgt_sect = ptr2_sec_q[DMSA_SECT_W-1:0];
            tgt_ofs = ptr2_lo_q;
         end
         default:
         begin
            tgt_sect = raw_sect;
            tgt_ofs = raw_ofs;
         end
      endcase
   end

   // a pointer aimed at a port lands on nothing rather than chaining
   assign tgt_port = dmsa_port_of(tgt_sect, tgt_ofs);

   // upper half of each sector is storage, lower half of sector zero special registers
   assign gp_sel = tgt_ofs[7] && (32'(tgt_sect) < NUM_SECTORS);
   assign sfr_sel = !tgt_ofs[7] && (tgt_sect == '0);
   assign gp_idx = {tgt_sect, tgt_ofs[DMSA_GP_W-1:0]};

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   // unused offsets and the ports themselves fall to zero here
   always_comb
   begin
      old_byte = DMSA_ZERO;
      if (gp_sel)
      begin
         old_byte = gp_mem[gp_idx];
      end
      else if (sfr_sel)
      begin
         case (tgt_ofs)
            DMSA_OFS_PTR0: old_byte = ptr0_q;
            DMSA_OFS_PTR1_LO: old_byte = ptr1_lo_q;
            DMSA_OFS_PTR1_SEC: old_byte = ptr1_sec_q;
            DMSA_OFS_PTR2_LO: old_byte = ptr2_lo_q;
            DMSA_OFS_PTR2_SEC: old_byte = ptr2_sec_q;
            DMSA_OFS_PBANK: old_byte = {7'h00, pbank_q};
            default: old_byte = DMSA_ZERO;
         endcase
      end
   end

   assign new_byte = dmsa_merge(old_byte, ACC_REQ);

   // ----------------------------------------------------------------
   // storage writes
   // ----------------------------------------------------------------
   // no reset on the array: storage content is undefined after power-up
   always_ff @(posedge SYS_CLK)
   begin
      if (ACC_EN && ACC_REQ.wr && gp_sel)
      begin
         gp_mem[gp_idx] <= new_byte;
      end
   end

   // ----------------------------------------------------------------
   // pointer and bank registers
   // ----------------------------------------------------------------
   // standard instructions move between sectors only by loading these
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         ptr0_q <= DMSA_PTR_RST;
         ptr1_lo_q <= DMSA_PTR_RST;
         ptr1_sec_q <= DMSA_PTR_RST;
         ptr2_lo_q <= DMSA_PTR_RST;
         ptr2_sec_q <= DMSA_PTR_RST;
         pbank_q <= DMSA_PBANK_RST;
      end
      else if (ACC_EN && ACC_REQ.wr && sfr_sel)
      begin
         case (tgt_ofs)
            DMSA_OFS_PTR0: ptr0_q <= new_byte;
            DMSA_OFS_PTR1_LO: ptr1_lo_q <= new_byte;
            DMSA_OFS_PTR1_SEC: ptr1_sec_q <= new_byte;
            DMSA_OFS_PTR2_LO: ptr2_lo_q <= new_byte;
            DMSA_OFS_PTR2_SEC: ptr2_sec_q <= new_byte;
            DMSA_OFS_PBANK: pbank_q <= new_byte[DMSA_PBANK_BIT];
            default: pbank_q <= pbank_q; // ports and unused: no effect
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read answer
   // ----------------------------------------------------------------
   // registered so RD_DATA never glitches with the address
   always_ff @(posedge SYS_CLK)
   begin
      if (!RESET_N)
      begin
         rd_data_q <= DMSA_ZERO;
         rd_valid_q <= 1'b0;
      end
      else
      begin
         rd_valid_q <= ACC_EN && !ACC_REQ.wr;
         if (ACC_EN && !ACC_REQ.wr)
         begin
            rd_data_q <= old_byte;
         end
      end
   end

   assign RD_DATA = rd_data_q;
   assign RD_VALID = rd_valid_q;
   assign PROG_BANK = pbank_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_port1_sector;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && raw_port == DMSA_PORT1)
         |-> (tgt_sect == ptr1_sec_q[DMSA_SECT_W-1:0] && tgt_ofs == ptr1_lo_q);
   endproperty
   a_port1_sector: assert property (p_port1_sector)
      else $error("port one did not follow its pointer pair");

   property p_port2_location;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && raw_port == DMSA_PORT2)
         |-> (tgt_ofs == ptr2_lo_q && tgt_sect == ptr2_sec_q[DMSA_SECT_W-1:0]);
   endproperty
   a_port2_location: assert property (p_port2_location)
      else $error("port two did not follow its pointer pair");

   property p_ext_direct;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && ACC_REQ.ext && raw_port == DMSA_PORT_NONE)
         |-> ({tgt_sect, tgt_ofs} == ACC_REQ.addr);
   endproperty
   a_ext_direct: assert property (p_ext_direct)
      else $error("extended address not used as sector and location");

   property p_port0_sector0;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && raw_port == DMSA_PORT0) |-> (tgt_sect == '0 && tgt_ofs == ptr0_q);
   endproperty
   a_port0_sector0: assert property (p_port0_sector0)
      else $error("port zero left sector zero");

   property p_std_sector0;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && !ACC_REQ.ext && raw_port == DMSA_PORT_NONE) |-> (tgt_sect == '0);
   endproperty
   a_std_sector0: assert property (p_std_sector0)
      else $error("standard access left sector zero");

   property p_unused_zero;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && !ACC_REQ.wr && !gp_sel && (tgt_port != DMSA_PORT_NONE || !sfr_sel))
         |=> (RD_VALID && RD_DATA == 8'h00);
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused or port location read nonzero");

   property p_port_write_nop;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && ACC_REQ.wr && tgt_port != DMSA_PORT_NONE)
         |=> ($stable(ptr0_q) && $stable(ptr1_lo_q) && $stable(ptr1_sec_q)
              && $stable(ptr2_lo_q) && $stable(ptr2_sec_q) && $stable(pbank_q));
   endproperty
   a_port_write_nop: assert property (p_port_write_nop)
      else $error("write to a port as target changed a register");

   property p_bit_set;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && ACC_REQ.wr && ACC_REQ.bitop && gp_sel)
         |=> (gp_mem[$past(gp_idx)][$past(ACC_REQ.bitsel)] == $past(ACC_REQ.bitval)
              && (gp_mem[$past(gp_idx)] | (8'h01 << $past(ACC_REQ.bitsel)))
                 == ($past(old_byte) | (8'h01 << $past(ACC_REQ.bitsel))));
   endproperty
   a_bit_set: assert property (p_bit_set)
      else $error("bit operation disturbed other bits");

   property p_pbank_ro;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && !ACC_REQ.wr && sfr_sel && tgt_ofs == DMSA_OFS_PBANK)
         |=> (RD_DATA[7:1] == 7'h00 && RD_DATA[0] == PROG_BANK);
   endproperty
   a_pbank_ro: assert property (p_pbank_ro)
      else $error("program bank upper bits not zero");

   // every taken read is answered exactly one cycle later
   property p_read_answer;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && !ACC_REQ.wr) |=> RD_VALID;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read not answered one cycle later");

   property p_write_silent;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      !(ACC_EN && !ACC_REQ.wr) |=> !RD_VALID;
   endproperty
   a_write_silent: assert property (p_write_silent)
      else $error("read marker without a read");

   property p_gp_write;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && ACC_REQ.wr && !ACC_REQ.bitop && gp_sel)
         |=> (gp_mem[$past(gp_idx)] == $past(ACC_REQ.wdata));
   endproperty
   a_gp_write: assert property (p_gp_write)
      else $error("storage write did not land");

   // the bank bit moves only on a write aimed at its own offset
   property p_pbank_isolated;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      !(ACC_EN && ACC_REQ.wr && sfr_sel && tgt_ofs == DMSA_OFS_PBANK)
         |=> $stable(pbank_q);
   endproperty
   a_pbank_isolated: assert property (p_pbank_isolated)
      else $error("program bank changed without its own write");

   property p_ptr_load;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      (ACC_EN && ACC_REQ.wr && !ACC_REQ.bitop && sfr_sel && tgt_ofs == DMSA_OFS_PTR2_SEC)
         |=> (ptr2_sec_q == $past(ACC_REQ.wdata));
   endproperty
   a_ptr_load: assert property (p_ptr_load)
      else $error("pointer two sector not loaded");

   c_port1_read: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
      ACC_EN && !ACC_REQ.wr && raw_port == DMSA_PORT1 && tgt_sect != '0);
   c_ext_write: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
      ACC_EN && ACC_REQ.wr && ACC_REQ.ext && gp_sel && tgt_sect != '0);
   c_bit_clear: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
      ACC_EN && ACC_REQ.wr && ACC_REQ.bitop && !ACC_REQ.bitval && gp_sel);
   c_port0_redirect: cover property (@(posedge SYS_CLK) disable iff (!RESET_N)
      ACC_EN && raw_port == DMSA_PORT0 && tgt_port == DMSA_PORT_NONE);

endmodule : dmsa_core

// File: verification/dmsa_cpu_model.sv
// cpu core model: issues one data access at a time to the addressing block
// assumes the block answers a read within two edges of the taken edge
`timescale 1ns/1ns
module dmsa_cpu_model
(
   input wire logic clk, // system clock
   output dmsa_pkg::dmsa_req_s req, // access details
   output logic en, // access request
   input wire logic [7:0] rd_data, // read result
   input wire logic rd_valid // read marker
);
   import dmsa_pkg::*;

   // idle until the first access
   initial
   begin
      en = 1'b0;
      req = '0;
   end

   // ----------------------------------------------------------------
   // one access, held until the taken edge
   // ----------------------------------------------------------------
   task automatic acc(input dmsa_req_s r, output logic [7:0] rd, output logic ok);
      int n;
      rd = 8'h00;
      ok = 1'b1;
      @(posedge clk);
      en <= 1'b1;
      req <= r;
      @(posedge clk);
      en <= 1'b0;
      req <= ~r; // released lines never keep a stale copy
      if (r.wr == 1'b0)
      begin
         ok = 1'b0;
         for (n = 0; n < 3 && !ok; n++)
         begin
            #1;
            if (rd_valid === 1'b1)
            begin
               rd = rd_data;
               ok = 1'b1;
            end
            else
               @(posedge clk);
         end
      end
   endtask : acc
endmodule : dmsa_cpu_model

// File: verification/dmsa_bench.sv
// self-checking bench for the data memory sector addressing block
// assumes the cpu model in dmsa_cpu_model drives every access
`timescale 1ns/1ns
module dmsa_bench;
   import dmsa_pkg::*;
   logic sys_clk;
   logic reset_n;
   logic acc_en;
   logic rd_valid;
   logic prog_bank;
   logic [7:0] rd_data;
   dmsa_req_s acc_req;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   int i;
   logic [7:0] e;

   dmsa_core #(.NUM_SECTORS(16)) dmsa_core_i (.SYS_CLK(sys_clk), .RESET_N(reset_n),
      .ACC_EN(acc_en), .ACC_REQ(acc_req), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .PROG_BANK(prog_bank));
   dmsa_cpu_model dmsa_cpu_model_i (.clk(sys_clk), .req(acc_req), .en(acc_en),
      .rd_data(rd_data), .rd_valid(rd_valid));

   // 25 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // compare and access helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chkf(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkf

   function automatic logic [11:0] z(input logic [7:0] a);
      return {4'h0, a};
   endfunction : z

   task automatic wr(input logic x, input logic [11:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic ok;
      dmsa_cpu_model_i.acc('{1'b1, x, 1'b0, 1'b0, 3'd0, a, d}, r, ok);
   endtask : wr

   task automatic bt(input logic [11:0] a, input logic v, input logic [2:0] s);
      logic [7:0] r;
      logic ok;
      dmsa_cpu_model_i.acc('{1'b1, 1'b1, 1'b1, v, s, a, 8'h00}, r, ok);
   endtask : bt

   task automatic rd(input logic x, input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] r;
      logic ok;
      dmsa_cpu_model_i.acc('{1'b0, x, 1'b0, 1'b0, 3'd0, a, 8'h00}, r, ok);
      chkf(ok, 1'b1);
      chk(r, exp);
   endtask : rd

   task automatic tally_and_finish;
      if (n_fail == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   // hang guard; the sequence needs under two hundred cycles
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      reset_n <= 1'b0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1;
      chkf(prog_bank, DMSA_PBANK_RST);
      rd(0, z(DMSA_OFS_PTR1_SEC), DMSA_PTR_RST);
      // direct extended reach of sectors one and fifteen, plus sector zero
      wr(1, 12'h1f0, 8'ha5);
      wr(1, 12'hf80, 8'h3c);
      wr(0, 12'h080, 8'h11);
      rd(1, 12'h1f0, 8'ha5);
      rd(1, 12'hf80, 8'h3c);
      rd(0, 12'h080, 8'h11);
      rd(1, 12'h080, 8'h11);
      // unused places read zero, writes lost
      wr(0, 12'h027, 8'hff);
      rd(0, 12'h027, 8'h00);
      rd(1, 12'h327, 8'h00);
      // port one with stray upper sector bits
      wr(0, z(DMSA_OFS_PTR1_SEC), 8'h31);
      wr(0, z(DMSA_OFS_PTR1_LO), 8'hf0);
      rd(0, z(DMSA_OFS_IPORT1), 8'ha5);
      rd(0, z(DMSA_OFS_PTR1_SEC), 8'h31);
      wr(0, z(DMSA_OFS_IPORT1), 8'h5a);
      rd(1, 12'h1f0, 8'h5a);
      // port two into the top sector
      wr(0, z(DMSA_OFS_PTR2_SEC), 8'h0f);
      wr(0, z(DMSA_OFS_PTR2_LO), 8'h80);
      rd(0, z(DMSA_OFS_IPORT2), 8'h3c);
      // port zero stays in sector zero
      wr(0, z(DMSA_OFS_PTR0), 8'h80);
      rd(0, z(DMSA_OFS_IPORT0), 8'h11);
      wr(0, z(DMSA_OFS_IPORT0), 8'h77);
      rd(1, 12'h080, 8'h77);
      // a port aimed at a port is a null target
      wr(0, z(DMSA_OFS_PTR1_SEC), 8'h00);
      wr(0, z(DMSA_OFS_PTR1_LO), DMSA_OFS_IPORT1);
      wr(0, z(DMSA_OFS_IPORT1), 8'hee);
      rd(0, z(DMSA_OFS_IPORT1), 8'h00);
      wr(0, z(DMSA_OFS_PTR0), DMSA_OFS_IPORT0);
      rd(0, z(DMSA_OFS_IPORT0), 8'h00);
      rd(1, 12'h1f0, 8'h5a);
      // program bank never steers data sectors
      wr(0, z(DMSA_OFS_PBANK), 8'hff);
      rd(0, z(DMSA_OFS_PBANK), 8'h01);
      chkf(prog_bank, 1'b1);
      rd(0, z(DMSA_OFS_IPORT2), 8'h3c);
      rd(1, 12'hf80, 8'h3c);
      // mid-run reset clears pointers and bank, storage keeps its bytes
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      #1;
      chkf(prog_bank, DMSA_PBANK_RST);
      rd(0, z(DMSA_OFS_PTR2_SEC), DMSA_PTR_RST);
      rd(0, z(DMSA_OFS_PTR0), DMSA_PTR_RST);
      rd(1, 12'hf80, 8'h3c);
      // single-bit set then clear, neighbours kept
      wr(1, 12'h5f3, 8'h00);
      e = 8'h00;
      for (i = 0; i < 8; i++)
      begin
         bt(12'h5f3, 1'b1, i[2:0]);
         e = e | (8'h01 << i);
         rd(1, 12'h5f3, e);
      end
      bt(12'h5f3, 1'b0, 3'd4);
      rd(1, 12'h5f3, 8'hef);
      tally_and_finish();
   end
endmodule : dmsa_bench
